// [verilog/i2c_master_defs.vh]
// register map, field positions and reset values of the two-wire master engine
// Summary of operation
// - prescaled tick is clock over two^(exponent+1)
// - low, high, start-stop, data counts time phases
// - clock low equals hold, setup plus low
// - high phase counts only once clock line high
// - no new transfer while error flags set
// - automatic stop after address or data nack
// - nack leaves live bit; clearing loads queued command
// - start then address with write bit
// - ninth pulse samples address acknowledge, flags nack
// - write bytes stretch until holding register full
// - zero-byte command sends only start, address, stop
// - data nack flag, interrupt when enabled
// - transmit slot free drives dma transmit request
// - command done flag on command completion
// - start then address with read bit
// - read bytes stretch, store, ack all but last
// - receive byte waiting drives dma receive request
// - arbitration loss releases bus, waits for stop
// - busy bus: wait for stop before start
// - bus busy state is not software visible
// - bytes are eight bits, msb first, acked
// - start after stopless command gives repeated start
`ifndef I2C_MASTER_DEFS_VH
`define I2C_MASTER_DEFS_VH
`define OFF_CLOCK_WAVEFORM 8'h00
`define OFF_CONTROL 8'h04
`define OFF_CURRENT_CMD 8'h08
`define OFF_QUEUED_CMD 8'h0C
`define OFF_STATUS 8'h10
`define OFF_IRQ_ENABLE 8'h14
`define OFF_STATUS_CLEAR 8'h18
`define OFF_TX_HOLD 8'h1C
`define OFF_RX_HOLD 8'h20
`define RST_CLOCK_WAVEFORM 32'h00000000
`define RST_CONTROL 32'h00000001
`define RST_IRQ_ENABLE 32'h00000000
`define CW_LOW_LSB 0
`define CW_LOW_MSB 7
`define CW_HIGH_LSB 8
`define CW_HIGH_MSB 15
`define CW_STARTSTOP_LSB 16
`define CW_STARTSTOP_MSB 23
`define CW_DATA_LSB 24
`define CW_DATA_MSB 27
`define CW_PRESCALE_LSB 28
`define CW_PRESCALE_MSB 30
`define CTL_ENABLE 0
`define CMD_READ 0
`define CMD_ADDR_LSB 1
`define CMD_ADDR_MSB 7
`define CMD_START 13
`define CMD_STOP 14
`define CMD_LIVE 15
`define CMD_NB_LSB 16
`define CMD_NB_MSB 23
`define STA_RX_WAIT 0
`define STA_TX_FREE 1
`define STA_DONE 3
`define STA_ADDR_NACK 8
`define STA_DATA_NACK 9
`define STA_ARB_LOST 10
`endif

// [verilog/i2c_prescaler.v]
// prescaler that turns the core clock into a one-cycle tick
`timescale 1ns/1ps
module i2c_prescaler #(
  parameter EXPW = 3
) (
  input wire core_clk,
  input wire rst,
  input wire [EXPW-1:0] exponent,
  output reg tick
);
  localparam CW = (1 << EXPW); // counter wide enough for the largest division
  reg [CW-1:0] divCnt; // free running divider count
  wire [CW-1:0] limit; // last count of one tick period
  // all ones shifted down: period of two^(exponent+1) core cycles
  assign limit = {CW{1'b1}} >> ((CW - 1) - exponent);
  // count up and pulse tick at the limit
  always @(posedge core_clk) begin
    if (rst) begin
      divCnt <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (divCnt >= limit) begin
      divCnt <= {CW{1'b0}};
      tick <= 1'b1;
    end else begin
      divCnt <= divCnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // i2c_prescaler

// [verilog/i2c_master_engine.v]
// two-wire bus master engine with register port and bit sequencer
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "i2c_master_defs.vh"
module i2c_master_engine (
  input wire core_clk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdData,
  input wire sclIn,
  output reg sclOut,
  output reg sclOe,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  output reg transmitSlotFree,
  output reg receiveByteWaiting,
  output reg irq
);
  // one-hot sequencer states
  localparam S_IDLE = 10'b0000000001;
  localparam S_START = 10'b0000000010;
  localparam S_LOWH = 10'b0000000100;
  localparam S_LOWS = 10'b0000001000;
  localparam S_HIGH = 10'b0000010000;
  localparam S_STOP1 = 10'b0000100000;
  localparam S_STOP2 = 10'b0001000000;
  localparam S_STOP3 = 10'b0010000000;
  localparam S_RSTA1 = 10'b0100000000;
  localparam S_RSTA2 = 10'b1000000000;

  reg [31:0] clockWaveform; // timing counts and prescale exponent
  reg enable; // master enable from control register
  reg [31:0] currentCommand; // command being executed
  reg [31:0] queuedCommand; // next command waiting
  reg [31:0] irqEnable; // interrupt enable per status bit
  reg [7:0] transmitHold; // byte written by software or dma
  reg [7:0] receiveHold; // last byte received
  reg commandDone; // command finished flag
  reg addrNack; // address not acknowledged
  reg dataNack; // data not acknowledged
  reg arbLost; // arbitration lost
  reg [9:0] state; // sequencer state
  reg [8:0] cnt; // prescaled tick counter of the phase
  reg [3:0] bitIdx; // bit within byte, 8 is the acknowledge
  reg [7:0] shreg; // shift register for address and data
  reg [7:0] byteCount; // remaining data bytes
  reg addrPhase; // current byte is the address
  reg isRead; // command is a read
  reg stopAfter; // command asks for stop at the end
  reg errStop; // stop caused by a nack
  reg held; // bus kept with clock low after a stopless command
  reg busBusy; // bus activity seen between start and stop
  reg prevSda; // last sampled data line
  reg prevScl; // last sampled clock line
  wire tick; // prescaled time base
  reg stall; // freezes the phase counter
  reg [8:0] tgt; // last count of the phase
  wire timeUp; // phase time elapsed
  wire errAny; // any error flag blocking starts
  wire [15:0] statusWord; // status as software reads it
  wire wrStatusClear; // software write to the status clear register

  i2c_prescaler #(
    .EXPW(3)
  ) u_prescaler (
    .core_clk(core_clk),
    .rst(rst),
    .exponent(clockWaveform[`CW_PRESCALE_MSB:`CW_PRESCALE_LSB]),
    .tick(tick)
  );

  assign errAny = addrNack | dataNack | arbLost;
  assign wrStatusClear = regWr && (regAddr == `OFF_STATUS_CLEAR);
  // bus busy state is deliberately left out of the status word
  assign statusWord = {5'h00, arbLost, dataNack, addrNack, 4'h0, commandDone, 1'b0,
    transmitSlotFree, receiveByteWaiting};
  assign timeUp = tick && !stall && (cnt >= tgt);

  // phase length and stretch condition of the current state
  always @* begin
    stall = 1'b0;
    tgt = 9'h000;
    case (state)
      S_START: tgt = {1'b0, clockWaveform[`CW_STARTSTOP_MSB:`CW_STARTSTOP_LSB]};
      S_LOWH: begin
        tgt = {5'h00, clockWaveform[`CW_DATA_MSB:`CW_DATA_LSB]}; // data hold
        // first bit of a data byte waits for the holding registers
        if (bitIdx == 4'h0 && !addrPhase) begin
          stall = isRead ? receiveByteWaiting : transmitSlotFree;
        end
      end
      // data setup plus programmed low
      S_LOWS: tgt = {1'b0, clockWaveform[`CW_LOW_MSB:`CW_LOW_LSB]} +
        {5'h00, clockWaveform[`CW_DATA_MSB:`CW_DATA_LSB]};
      S_HIGH: begin
        tgt = {1'b0, clockWaveform[`CW_HIGH_MSB:`CW_HIGH_LSB]};
        stall = !sclIn; // wait for release by stretching party
      end
      S_STOP1: tgt = {5'h00, clockWaveform[`CW_DATA_MSB:`CW_DATA_LSB]};
      S_STOP2: begin
        tgt = {1'b0, clockWaveform[`CW_STARTSTOP_MSB:`CW_STARTSTOP_LSB]};
        stall = !sclIn;
      end
      S_STOP3: tgt = {1'b0, clockWaveform[`CW_LOW_MSB:`CW_LOW_LSB]}; // bus free time
      S_RSTA1: tgt = {1'b0, clockWaveform[`CW_LOW_MSB:`CW_LOW_LSB]};
      S_RSTA2: begin
        tgt = {1'b0, clockWaveform[`CW_STARTSTOP_MSB:`CW_STARTSTOP_LSB]};
        stall = !sclIn;
      end
      default: tgt = 9'h000;
    endcase
  end

  // watch the lines for start and stop conditions of any master
  always @(posedge core_clk) begin
    if (rst) begin
      prevSda <= 1'b1;
      prevScl <= 1'b1;
      busBusy <= 1'b0;
    end else begin
      prevSda <= sdaIn;
      prevScl <= sclIn;
      if (sclIn && prevScl && prevSda && !sdaIn) begin
        busBusy <= 1'b1; // start seen
      end else if (sclIn && prevScl && !prevSda && sdaIn) begin
        busBusy <= 1'b0; // stop seen
      end
    end
  end

  // end of a command: stop if asked, otherwise keep the bus
  task finishCmd;
    begin
      cnt <= 9'h000;
      if (stopAfter) begin
        state <= S_STOP1;
        sclOe <= 1'b1;
        errStop <= 1'b0;
      end else begin
        state <= S_IDLE;
        held <= 1'b1;
        commandDone <= 1'b1;
        currentCommand[`CMD_LIVE] <= 1'b0;
      end
    end
  endtask

  // nack: stop on the bus and keep the command live
  task nackStop;
    begin
      cnt <= 9'h000;
      state <= S_STOP1;
      sclOe <= 1'b1;
      errStop <= 1'b1; // live bit stays set
    end
  endtask

  // register file and bit sequencer
  always @(posedge core_clk) begin
    if (rst) begin
      clockWaveform <= `RST_CLOCK_WAVEFORM;
      enable <= (`RST_CONTROL != 32'h00000000);
      currentCommand <= 32'h00000000;
      queuedCommand <= 32'h00000000;
      irqEnable <= `RST_IRQ_ENABLE;
      transmitHold <= 8'h00;
      receiveHold <= 8'h00;
      transmitSlotFree <= 1'b1;
      receiveByteWaiting <= 1'b0;
      commandDone <= 1'b0;
      addrNack <= 1'b0;
      dataNack <= 1'b0;
      arbLost <= 1'b0;
      state <= S_IDLE; // both lines released
      cnt <= 9'h000;
      bitIdx <= 4'h0;
      shreg <= 8'h00;
      byteCount <= 8'h00;
      addrPhase <= 1'b0;
      isRead <= 1'b0;
      stopAfter <= 1'b0;
      errStop <= 1'b0;
      held <= 1'b0;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      regRdData <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      sclOut <= 1'b0; // open drain: only the enable moves
      sdaOut <= 1'b0;
      irq <= |(irqEnable[15:0] & statusWord);
      // phase counter advances on unstalled ticks
      if (tick && !stall) begin
        cnt <= cnt + 9'h001;
      end
      // register reads, data valid one cycle after the strobe
      regRdData <= 32'h00000000;
      if (regRd) begin
        if (regAddr == `OFF_CLOCK_WAVEFORM) begin
          regRdData <= clockWaveform;
        end else if (regAddr == `OFF_CONTROL) begin
          regRdData <= {31'h00000000, enable};
        end else if (regAddr == `OFF_CURRENT_CMD) begin
          regRdData <= currentCommand;
        end else if (regAddr == `OFF_QUEUED_CMD) begin
          regRdData <= queuedCommand;
        end else if (regAddr == `OFF_STATUS) begin
          regRdData <= {16'h0000, statusWord};
        end else if (regAddr == `OFF_IRQ_ENABLE) begin
          regRdData <= irqEnable;
        end else if (regAddr == `OFF_RX_HOLD) begin
          regRdData <= {24'h000000, receiveHold};
          receiveByteWaiting <= 1'b0; // reading empties the holding register
        end
      end
      // status clear: write one to clear, a set in this cycle wins below
      if (wrStatusClear) begin
        commandDone <= commandDone & ~regWrData[`STA_DONE];
        addrNack <= addrNack & ~regWrData[`STA_ADDR_NACK];
        dataNack <= dataNack & ~regWrData[`STA_DATA_NACK];
        arbLost <= arbLost & ~regWrData[`STA_ARB_LOST];
      end
      // register writes
      if (regWr) begin
        if (regAddr == `OFF_CLOCK_WAVEFORM) begin
          clockWaveform <= regWrData;
        end else if (regAddr == `OFF_CONTROL) begin
          enable <= regWrData[`CTL_ENABLE];
        end else if (regAddr == `OFF_CURRENT_CMD) begin
          currentCommand <= regWrData;
        end else if (regAddr == `OFF_QUEUED_CMD) begin
          queuedCommand <= regWrData;
        end else if (regAddr == `OFF_IRQ_ENABLE) begin
          irqEnable <= regWrData;
        end else if (regAddr == `OFF_TX_HOLD) begin
          transmitHold <= regWrData[7:0];
          transmitSlotFree <= 1'b0;
        end
      end
      case (state)
        S_IDLE: begin
          if (!currentCommand[`CMD_LIVE] && queuedCommand[`CMD_LIVE]) begin
            currentCommand <= queuedCommand;
            queuedCommand[`CMD_LIVE] <= 1'b0;
          end else if (currentCommand[`CMD_LIVE] && enable && !errAny) begin
            isRead <= currentCommand[`CMD_READ];
            stopAfter <= currentCommand[`CMD_STOP];
            byteCount <= currentCommand[`CMD_NB_MSB:`CMD_NB_LSB];
            cnt <= 9'h000;
            if (currentCommand[`CMD_START]) begin
              if (held) begin
                state <= S_RSTA1; // repeated start
                sdaOe <= 1'b0;
              end else if (!busBusy) begin
                state <= S_START;
                sdaOe <= 1'b1;
              end
            end else if (held) begin
              // continuation of a held transfer without address
              addrPhase <= 1'b0;
              bitIdx <= 4'h0;
              if (currentCommand[`CMD_NB_MSB:`CMD_NB_LSB] == 8'h00) begin
                finishCmd;
              end else begin
                state <= S_LOWH;
              end
            end else begin
              commandDone <= 1'b1; // nothing to continue
              currentCommand[`CMD_LIVE] <= 1'b0;
            end
          end
        end
        S_START: begin
          // data low while clock high, then clock low
          if (timeUp) begin
            held <= 1'b0;
            sclOe <= 1'b1;
            shreg <= {currentCommand[`CMD_ADDR_MSB:`CMD_ADDR_LSB], isRead};
            addrPhase <= 1'b1;
            bitIdx <= 4'h0;
            cnt <= 9'h000;
            state <= S_LOWH;
          end
        end
        S_LOWH: begin
          sclOe <= 1'b1;
          if (timeUp) begin
            cnt <= 9'h000;
            state <= S_LOWS;
            if (bitIdx == 4'h8) begin
              // address and write acks are released, read ack all but last
              sdaOe <= (isRead && !addrPhase) ? (byteCount != 8'h01) : 1'b0;
            end else if (isRead && !addrPhase) begin
              sdaOe <= 1'b0;
            end else if (bitIdx == 4'h0 && !addrPhase) begin
              shreg <= transmitHold;
              sdaOe <= ~transmitHold[7]; // msb first
              transmitSlotFree <= 1'b1;
            end else begin
              sdaOe <= ~shreg[7];
            end
          end
        end
        S_LOWS: begin
          if (timeUp) begin
            cnt <= 9'h000;
            sclOe <= 1'b0;
            state <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (timeUp) begin
            cnt <= 9'h000;
            if (bitIdx != 4'h8) begin
              shreg <= {shreg[6:0], sdaIn};
              bitIdx <= bitIdx + 4'h1;
              if (!(isRead && !addrPhase) && !sdaOe && !sdaIn) begin
                // sent a one but line is low: give up the bus
                arbLost <= 1'b1;
                sdaOe <= 1'b0;
                held <= 1'b0;
                state <= S_IDLE;
              end else begin
                sclOe <= 1'b1;
                state <= S_LOWH;
              end
            end else begin
              sclOe <= 1'b1;
              bitIdx <= 4'h0;
              if (addrPhase) begin
                addrPhase <= 1'b0;
                if (sdaIn) begin
                  addrNack <= 1'b1;
                  nackStop;
                end else if (byteCount == 8'h00) begin
                  finishCmd; // no data bytes
                end else begin
                  state <= S_LOWH;
                end
              end else if (!isRead && sdaIn) begin
                dataNack <= 1'b1;
                nackStop;
              end else begin
                if (isRead) begin
                  receiveHold <= shreg;
                  receiveByteWaiting <= 1'b1;
                end
                byteCount <= byteCount - 8'h01;
                if (byteCount == 8'h01) begin
                  finishCmd;
                end else begin
                  state <= S_LOWH;
                end
              end
            end
          end
        end
        S_STOP1: begin
          // clock low, data pulled low ahead of the stop
          sdaOe <= 1'b1;
          if (timeUp) begin
            cnt <= 9'h000;
            sclOe <= 1'b0;
            state <= S_STOP2;
          end
        end
        S_STOP2: begin
          if (timeUp) begin
            cnt <= 9'h000;
            sdaOe <= 1'b0; // data rises with clock high
            state <= S_STOP3;
          end
        end
        S_STOP3: begin
          // bus free time before anything new
          if (timeUp) begin
            held <= 1'b0;
            state <= S_IDLE;
            if (!errStop) begin
              commandDone <= 1'b1;
              currentCommand[`CMD_LIVE] <= 1'b0;
            end
          end
        end
        S_RSTA1: begin
          if (timeUp) begin
            cnt <= 9'h000;
            sclOe <= 1'b0;
            state <= S_RSTA2;
          end
        end
        S_RSTA2: begin
          if (timeUp) begin
            cnt <= 9'h000;
            sdaOe <= 1'b1;
            state <= S_START;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // i2c_master_engine

// [verification/i2c_master_engine_sva.sv]
// checker of the two-wire master engine port behaviour
`timescale 1ns/1ps
module i2c_master_engine_chk (
  input wire core_clk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdData,
  input wire sclIn,
  input wire sclOe,
  input wire sdaIn,
  input wire sdaOe,
  input wire transmitSlotFree,
  input wire receiveByteWaiting,
  input wire irq
);
  reg cmdSeen; // a command register was written since reset
  reg [31:0] irqMask; // copy of the interrupt enable register
  // track command writes and the interrupt mask
  always @(posedge core_clk) begin
    if (rst) begin
      cmdSeen <= 1'b0;
      irqMask <= 32'h00000000;
    end else begin
      if (regWr && (regAddr == 8'h08 || regAddr == 8'h0C)) cmdSeen <= 1'b1;
      if (regWr && regAddr == 8'h14) irqMask <= regWrData;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h00000000)
    else $error("read data not zero outside read cycle");
  a_unmapped_read: assert property (regRd && regAddr == 8'h40 |=> regRdData == 32'h00000000)
    else $error("unmapped read not zero");
  a_status_tx: assert property (regRd && regAddr == 8'h10 |=> regRdData[1] == $past(transmitSlotFree))
    else $error("tx free status differs from dma request");
  a_status_rx: assert property (regRd && regAddr == 8'h10 |=> regRdData[0] == $past(receiveByteWaiting))
    else $error("rx waiting status differs from dma request");
  a_bus_hidden: assert property (regRd && regAddr == 8'h10 |=> (regRdData & 32'hFFFFF8F4) == 32'h00000000)
    else $error("undefined status bit set");
  a_idle_release: assert property (!cmdSeen |-> !sclOe && !sdaOe)
    else $error("lines driven before any command");
  a_tx_fill: assert property (regWr && regAddr == 8'h1C && transmitSlotFree |=> !transmitSlotFree)
    else $error("tx hold write did not fill slot");
  // a full holding register blocks a new byte, so the read must drain it
  a_rx_drain: assert property (regRd && regAddr == 8'h20 && receiveByteWaiting |=> !receiveByteWaiting)
    else $error("rx hold read did not drain");
  a_irq_masked: assert property ((irqMask[15:0] == 16'h0000) [*2] |-> !irq)
    else $error("interrupt while fully masked");
  a_stretch_wait: assert property (!sclOe && !sclIn |=> !sclOe)
    else $error("clock pulled again while held low by other party");
  c_rx_read: cover property (regRd && regAddr == 8'h20 && receiveByteWaiting);
  c_irq: cover property ($rose(irq));
  c_stretch: cover property (!sclOe && !sclIn);
endmodule // i2c_master_engine_chk
bind i2c_master_engine i2c_master_engine_chk i_chk (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sclIn(sclIn), .sclOe(sclOe),
  .sdaIn(sdaIn), .sdaOe(sdaOe), .transmitSlotFree(transmitSlotFree), .receiveByteWaiting(receiveByteWaiting),
  .irq(irq));

// [verification/i2c_slave_model.sv]
// behavioural bus slave answering the master engine
`timescale 1ns/1ps
module i2c_slave_model (
  input wire core_clk,
  input wire sclLine,
  input wire sdaLine,
  input wire ackAddr,
  input wire ackData,
  input wire stretch,
  input wire [7:0] txByte,
  output reg sclPull,
  output reg sdaPull,
  output reg [7:0] rxByte,
  output integer byteCnt,
  output integer startCnt,
  output integer stopCnt,
  output reg masterAck
);
  reg sclD, sdaD; // previous line levels
  reg [3:0] bitCnt; // bit position within the byte
  reg [7:0] sh; // incoming shift register
  reg addrPhase, readMode; // byte kind flags
  reg [4:0] hold; // stretch countdown
  initial begin
    {sclPull, sdaPull, sclD, sdaD, addrPhase, readMode, masterAck} = 7'h1C;
    {bitCnt, sh, rxByte, hold} = 0;
    {byteCnt, startCnt, stopCnt} = 0;
  end
  // edge detection on the wired lines, byte framing and answers
  always @(posedge core_clk) begin
    sclD <= sclLine;
    sdaD <= sdaLine;
    if (hold != 0) hold <= hold - 5'd1;
    sclPull <= (hold != 0);
    if (sclLine && sclD && sdaD && !sdaLine) begin
      bitCnt <= 0; // start condition
      addrPhase <= 1'b1;
      startCnt <= startCnt + 1;
      sdaPull <= 1'b0;
    end else if (sclLine && sclD && !sdaD && sdaLine) begin
      stopCnt <= stopCnt + 1; // stop condition
      sdaPull <= 1'b0;
    end else if (sclLine && !sclD) begin
      if (bitCnt < 8) begin
        sh <= {sh[6:0], sdaLine}; // msb first
        bitCnt <= bitCnt + 4'd1;
        if (bitCnt == 7) begin
          byteCnt <= byteCnt + 1;
          if (addrPhase) readMode <= sdaLine;
          // keep only bytes that the master sent
          if (addrPhase || !readMode) rxByte <= {sh[6:0], sdaLine};
        end
      end else begin
        bitCnt <= 0; // ninth bit ends the byte
        if (readMode && !addrPhase) masterAck <= !sdaLine;
        // a master nack ends the read, leaving data free for the stop
        if (readMode && !addrPhase && sdaLine) readMode <= 1'b0;
        addrPhase <= 1'b0;
      end
    end else if (!sclLine && sclD) begin
      hold <= stretch ? 5'd20 : 5'd0;
      if (bitCnt == 8) sdaPull <= addrPhase ? ackAddr : (!readMode && ackData);
      else if (readMode && !addrPhase) sdaPull <= !txByte[3'd7 - bitCnt[2:0]];
      else sdaPull <= 1'b0;
    end
  end
endmodule // i2c_slave_model

// [verification/tb_i2c_master_engine.sv]
// self-checking testbench of the two-wire master engine
`timescale 1ns/1ps
module tb_i2c_master_engine;
  reg core_clk, rst, regWr, regRd, ackAddr, ackData, stretch, tbSda;
  reg [7:0] regAddr, txByte;
  reg [31:0] regWrData, d;
  wire [31:0] regRdData;
  wire sclOe, sdaOe, transmitSlotFree, receiveByteWaiting, irq, sclPull, sdaPull;
  wire [7:0] rxByte;
  integer byteCnt, startCnt, stopCnt, num_errors, compares, b0, s0;
  wire masterAck, sclOut, sdaOut;
  wire sclIn = ~(sclOe | sclPull); // pulled-up wired clock line
  wire sdaIn = ~(sdaOe | sdaPull | tbSda); // pulled-up wired data line
  i2c_master_engine i_dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .transmitSlotFree(transmitSlotFree),
    .receiveByteWaiting(receiveByteWaiting), .irq(irq));
  i2c_slave_model i_slv (.core_clk(core_clk), .sclLine(sclIn), .sdaLine(sdaIn), .ackAddr(ackAddr),
    .ackData(ackData), .stretch(stretch), .txByte(txByte), .sclPull(sclPull), .sdaPull(sdaPull),
    .rxByte(rxByte), .byteCnt(byteCnt), .startCnt(startCnt), .stopCnt(stopCnt), .masterAck(masterAck));
  // clock generation, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task rd(input [7:0] a, output [31:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  // poll a status bit with a bounded number of reads
  task waitBit(input integer i, input reg v);
    integer n;
    n = 0;
    d = 32'h0;
    rd(8'h10, d);
    while (d[i] !== v && n < 4000) begin
      rd(8'h10, d);
      n = n + 1;
    end
    if (n == 4000) begin
      chk(32'h0, 32'h1); // waiting for status bit ran out
      finish_test;
    end
  endtask
  function [31:0] mkCmd(input [6:0] a, input r, input [7:0] nb, input st, input sp);
    mkCmd = {8'h00, nb, 1'b1, sp, st, 5'h00, a, r};
  endfunction
  task t_reset;
    rd(8'h04, d); chk(d, 32'h00000001);
    rd(8'h00, d); chk(d, 32'h00000000);
    rd(8'h14, d); chk(d, 32'h00000000);
    rd(8'h10, d); chk(d, 32'h00000002);
    rd(8'h40, d); chk(d, 32'h00000000);
    chk({sclOe, sdaOe, transmitSlotFree}, 32'h1);
    chk({sclOut, sdaOut}, 32'h0);
    wr(8'h00, 32'h01020202);
  endtask
  task t_write;
    stretch <= 1'b1; b0 = byteCnt; s0 = stopCnt;
    wr(8'h08, mkCmd(7'h50, 1'b0, 8'h01, 1'b1, 1'b1)); repeat (600) @(posedge core_clk);
    chk(sclIn, 0);
    wr(8'h1C, 32'h000000A5); waitBit(3, 1'b1);
    chk(rxByte, 8'hA5); chk(byteCnt - b0, 2); chk(stopCnt - s0, 1);
    wr(8'h18, 32'h00000008); rd(8'h10, d); chk(d, 32'h00000002); stretch <= 1'b0;
  endtask
  task t_zero;
    b0 = byteCnt; s0 = stopCnt;
    wr(8'h08, mkCmd(7'h21, 1'b0, 8'h00, 1'b1, 1'b1)); waitBit(3, 1'b1);
    chk(byteCnt - b0, 1); chk(stopCnt - s0, 1); chk(rxByte, 8'h42);
    wr(8'h18, 32'h00000008);
  endtask
  // the slave records the master's acknowledge before the byte is reported
  task t_read;
    txByte <= 8'h3C; stretch <= 1'b1; s0 = stopCnt;
    wr(8'h08, mkCmd(7'h50, 1'b1, 8'h02, 1'b1, 1'b1)); waitBit(0, 1'b1);
    chk(rxByte, 8'hA1); chk(receiveByteWaiting, 1);
    chk(masterAck, 1);
    rd(8'h20, d); chk(d, 32'h3C); waitBit(0, 1'b1); chk(masterAck, 0);
    rd(8'h20, d); chk(d, 32'h3C); waitBit(3, 1'b1);
    chk(masterAck, 0); chk(stopCnt - s0, 1);
    wr(8'h18, 32'h00000008); stretch <= 1'b0;
  endtask
  task t_addr_nack;
    ackAddr <= 1'b0; s0 = stopCnt;
    wr(8'h08, mkCmd(7'h33, 1'b0, 8'h01, 1'b1, 1'b1)); waitBit(8, 1'b1);
    repeat (300) @(posedge core_clk);
    chk(stopCnt - s0, 1);
    rd(8'h08, d); chk(d[15], 1);
    b0 = startCnt; repeat (300) @(posedge core_clk); chk(startCnt - b0, 0);
    ackAddr <= 1'b1; wr(8'h08, 32'h0); wr(8'h18, 32'h00000100);
    repeat (300) @(posedge core_clk); chk(startCnt - b0, 0);
  endtask
  task t_data_nack;
    wr(8'h14, 32'h00000200); ackData <= 1'b0; s0 = stopCnt;
    wr(8'h08, mkCmd(7'h50, 1'b0, 8'h02, 1'b1, 1'b1)); wr(8'h1C, 32'h5A);
    waitBit(9, 1'b1); repeat (300) @(posedge core_clk);
    chk(irq, 1); chk(stopCnt - s0, 1);
    wr(8'h08, 32'h0); wr(8'h18, 32'h00000200); repeat (3) @(posedge core_clk);
    chk(irq, 0); ackData <= 1'b1; wr(8'h14, 32'h0);
  endtask
  task t_busy;
    @(posedge core_clk); tbSda <= 1'b1; // foreign start
    wr(8'h08, mkCmd(7'h21, 1'b0, 8'h00, 1'b1, 1'b1)); repeat (300) @(posedge core_clk);
    chk({sdaOe, sclOe}, 0);
    rd(8'h10, d); chk(d, 32'h00000002);
    @(posedge core_clk); tbSda <= 1'b0; // foreign stop
    waitBit(3, 1'b1); wr(8'h18, 32'h00000008);
  endtask
  // another master pulls data low while the first address bit is a one
  task t_arb;
    wr(8'h08, mkCmd(7'h7F, 1'b0, 8'h00, 1'b1, 1'b1)); repeat (12) @(posedge core_clk);
    tbSda <= 1'b1; repeat (100) @(posedge core_clk);
    chk({sdaOe, sclOe}, 0);
    tbSda <= 1'b0; rd(8'h10, d); chk(d, 32'h00000402);
    wr(8'h08, 32'h0); wr(8'h18, 32'h00000400);
  endtask
  // main sequence
  initial begin
    {rst, regWr, regRd, stretch, tbSda} = 5'h10;
    {ackAddr, ackData} = 2'h3;
    {regAddr, txByte, regWrData} = 0;
    num_errors = 0; compares = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset; t_write; t_zero; t_read; t_addr_nack; t_data_nack; t_busy; t_arb;
    finish_test;
  end
endmodule // tb_i2c_master_engine
